// ### rtl/adc_conversion_slot_scheduler.sv
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`default_nettype none
// Overview of operation
// - each slot holds trigger, channel and sample window; one conversion per start, two for a pair
// - slots are configured independently; identical settings all still convert
// - trigger comes from trigger field when interrupt-trigger select bits are zero; codes 1 and 2 pick an irq instead, code 3 picks no trigger
// - writing force register bits raises a start for those slots
// - 6-bit sample window field; sampling lasts field plus one cycles
// - conversion takes 13 clocks after the sample window ends
// - trigger code 9 is pwm unit 3 event a; channel codes pick inputs
// - result goes to the slot's own result register; a pair puts a in the even one and b in the odd one
// - one shared trigger starts all its slots, converted one after another
// - triggers: software, cpu timers 0-2, external irq two, pwm 1-7 a/b
// - converter irq one and two can retrigger slots per select registers
// - sequential mode: 4-bit channel field picks one input
// - simultaneous mode: top channel bit ignored, low three pick a/b pair
// - several pending slots are ordered by round robin by default
// - pointer holds last slot served; next higher slot wins, wrapping
// - pointer resets to 32, which gives slot 0 top priority
// - pointer reset by device reset, module reset bit or priority write
// - pending high-priority slot goes next; pointer not advanced by it
// - boundary field is first non-high slot; lower slots are high priority
// - simultaneous high-priority triggers: lower slot number goes first
module adc_conversion_slot_scheduler #(
	parameter int RES_W = 12
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// trigger sources
	input wire logic [2:0] timer_irq_i,
	input wire logic external_irq_two_i,
	input wire logic [6:0] pwm_event_a_i,
	input wire logic [6:0] pwm_event_b_i,
	input wire logic converter_irq_one_i,
	input wire logic converter_irq_two_i,
	// converter core
	input wire logic [RES_W-1:0] core_result_i,
	output logic sample_o,
	output logic convert_o,
	output logic [3:0] channel_o,
	output logic pair_mode_o,
	output logic result_done_o,
	output logic [3:0] result_slot_o
);
	localparam int N = adc_sched_pkg::NUM_SLOTS;

	// ***************
	// state
	// ***************
	logic [15:0] slot_control_reg_r [N];
	logic [RES_W-1:0] result_slot_reg_r [N];
	logic [7:0] sample_mode_r;
	logic [31:0] isel_r;
	logic [4:0] high_priority_boundary_r;
	logic [5:0] last_served_pointer_r;
	logic [N-1:0] pend_r;
	logic [N-1:0] pend_nxt;
	adc_sched_pkg::state_type state_r;
	logic [5:0] cnt_r;
	logic [3:0] cur_r;
	logic pair_r;
	logic [3:0] chan_r;
	logic done_r;
	logic [3:0] done_slot_r;
	logic [31:0] prdata_r;
	logic pslverr_r;

	// ***************
	// bus decode
	// ***************
	logic setup;
	logic wr_en;
	logic soft_rst;
	logic wr_prio;
	logic wr_force;
	logic wr_slot;
	logic [3:0] addr_idx;
	logic [31:0] rd_data;
	logic rd_err;

	assign setup = psel_i && !penable_i;
	assign wr_en = psel_i && penable_i && pwrite_i;
	assign addr_idx = paddr_i[5:2];
	// a misaligned address is refused, so it must not land in a slot either
	assign wr_slot = wr_en && (paddr_i[7:6] == adc_sched_pkg::SLOT_CTL_PAGE)
		&& (paddr_i[1:0] == 2'h0);
	assign wr_force = wr_en && (paddr_i == adc_sched_pkg::FORCE_OFS);
	assign wr_prio = wr_en && (paddr_i == adc_sched_pkg::PRIORITY_OFS);
	// module reset bit is a strobe: it clears the block and reads back as zero
	assign soft_rst = wr_en && (paddr_i == adc_sched_pkg::CTRL_ONE_OFS)
		&& pwdata_i[adc_sched_pkg::MOD_RESET_BIT];

	// ***************
	// field helpers
	// ***************
	function automatic logic [5:0] win_of(input logic [15:0] c);
		win_of = c[adc_sched_pkg::WIN_LSB +: adc_sched_pkg::WIN_W];
	endfunction : win_of

	function automatic logic [3:0] chan_of(input logic [15:0] c);
		chan_of = c[adc_sched_pkg::CHAN_LSB +: adc_sched_pkg::CHAN_W];
	endfunction : chan_of

	function automatic logic [4:0] tsel_of(input logic [15:0] c);
		tsel_of = c[adc_sched_pkg::TSEL_LSB +: adc_sched_pkg::TSEL_W];
	endfunction : tsel_of

	function automatic logic slot_hit(
		input logic [15:0] c,
		input logic [1:0] sel,
		input logic [adc_sched_pkg::TRIG_CODES-1:0] tv,
		input logic irq1,
		input logic irq2
	);
		logic [4:0] code;
		code = tsel_of(c);
		slot_hit = 1'b0;
		// an interrupt feedback selection takes the place of the trigger field
		unique case (sel)
			adc_sched_pkg::ISEL_NONE: begin
				if (int'(code) < adc_sched_pkg::TRIG_CODES) begin
					slot_hit = tv[code];
				end
			end
			adc_sched_pkg::ISEL_IRQ_ONE: begin
				slot_hit = irq1;
			end
			adc_sched_pkg::ISEL_IRQ_TWO: begin
				slot_hit = irq2;
			end
			default: begin
				slot_hit = 1'b0;
			end
		endcase
	endfunction : slot_hit

	// ***************
	// trigger vector
	// ***************
	// code 0 is software only, so it never fires from hardware
	logic [adc_sched_pkg::TRIG_CODES-1:0] trig_vec;

	always_comb begin
		trig_vec = '0;
		trig_vec[3:1] = timer_irq_i;
		trig_vec[4] = external_irq_two_i;
		for (int k = 0; k < 7; k++) begin
			trig_vec[5 + 2 * k] = pwm_event_a_i[k];
			trig_vec[6 + 2 * k] = pwm_event_b_i[k];
		end
	end

	logic [N-1:0] hits;

	always_comb begin
		for (int s = 0; s < N; s++) begin
			// every slot decodes on its own, so shared triggers start them all
			hits[s] = slot_hit(slot_control_reg_r[s], isel_r[2 * s +: 2], trig_vec,
				converter_irq_one_i, converter_irq_two_i);
		end
	end

	// ***************
	// arbitration
	// ***************
	logic gnt_valid;
	logic [3:0] gnt_idx;
	logic gnt_high;
	logic take;

	slot_arbiter #(
		.NUM(N)
	) u_arbiter (
		.pend_i(pend_r),
		.boundary_i(high_priority_boundary_r),
		.ptr_i(last_served_pointer_r),
		.valid_o(gnt_valid),
		.idx_o(gnt_idx),
		.high_o(gnt_high)
	);

	// only the idle state grants, which keeps one slot in flight
	assign take = (state_r == adc_sched_pkg::ST_IDLE) && gnt_valid;

	// ***************
	// pending flags
	// ***************
	always_comb begin
		pend_nxt = pend_r;
		if (take) begin
			pend_nxt[gnt_idx] = 1'b0;
		end
		// a new trigger in the clearing cycle is kept
		pend_nxt = pend_nxt | hits;
		if (wr_force) begin
			pend_nxt = pend_nxt | pwdata_i[N-1:0];
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pend_r <= '0;
		end else if (soft_rst) begin
			pend_r <= '0;
		end else begin
			pend_r <= pend_nxt;
		end
	end

	// ***************
	// round robin pointer
	// ***************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			last_served_pointer_r <= adc_sched_pkg::POINTER_RESET;
		end else if (soft_rst || wr_prio) begin
			last_served_pointer_r <= adc_sched_pkg::POINTER_RESET;
		end else if (take && !gnt_high) begin
			last_served_pointer_r <= {2'h0, gnt_idx};
		end
	end

	// ***************
	// conversion sequencer
	// ***************
	logic cnt_zero;
	logic [3:0] cap_idx;
	logic cap_en;
	logic [3:0] gnt_chan;

	assign gnt_chan = chan_of(slot_control_reg_r[gnt_idx]);

	assign cnt_zero = (cnt_r == 6'h00);
	assign cap_en = cnt_zero
		&& ((state_r == adc_sched_pkg::ST_CONV_A) || (state_r == adc_sched_pkg::ST_CONV_B));
	// the slot index names the result register, never the channel
	assign cap_idx = !pair_r ? cur_r
		: (state_r == adc_sched_pkg::ST_CONV_B) ? {cur_r[3:1], 1'b1}
		: {cur_r[3:1], 1'b0};

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r <= adc_sched_pkg::ST_IDLE;
			cnt_r <= 6'h00;
			cur_r <= 4'h0;
			pair_r <= 1'b0;
			chan_r <= 4'h0;
		end else if (soft_rst) begin
			state_r <= adc_sched_pkg::ST_IDLE;
			cnt_r <= 6'h00;
			cur_r <= 4'h0;
			pair_r <= 1'b0;
			chan_r <= 4'h0;
		end else begin
			unique case (state_r)
				adc_sched_pkg::ST_IDLE: begin
					if (take) begin
						state_r <= adc_sched_pkg::ST_SAMPLE;
						cur_r <= gnt_idx;
						cnt_r <= win_of(slot_control_reg_r[gnt_idx]);
						pair_r <= sample_mode_r[gnt_idx[3:1]];
						if (sample_mode_r[gnt_idx[3:1]]) begin
							chan_r <= {1'b0, gnt_chan[2:0]};
						end else begin
							chan_r <= gnt_chan;
						end
					end
				end
				adc_sched_pkg::ST_SAMPLE: begin
					if (cnt_zero) begin
						state_r <= adc_sched_pkg::ST_CONV_A;
						cnt_r <= 6'(adc_sched_pkg::CONV_CYCLES - 1);
					end else begin
						cnt_r <= cnt_r - 6'h01;
					end
				end
				adc_sched_pkg::ST_CONV_A: begin
					if (cnt_zero && pair_r) begin
						state_r <= adc_sched_pkg::ST_CONV_B;
						cnt_r <= 6'(adc_sched_pkg::CONV_CYCLES - 1);
					end else if (cnt_zero) begin
						state_r <= adc_sched_pkg::ST_IDLE;
					end else begin
						cnt_r <= cnt_r - 6'h01;
					end
				end
				adc_sched_pkg::ST_CONV_B: begin
					if (cnt_zero) begin
						state_r <= adc_sched_pkg::ST_IDLE;
					end else begin
						cnt_r <= cnt_r - 6'h01;
					end
				end
			endcase
		end
	end

	// ***************
	// results
	// ***************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int s = 0; s < N; s++) begin
				result_slot_reg_r[s] <= '0;
			end
		end else if (soft_rst) begin
			for (int s = 0; s < N; s++) begin
				result_slot_reg_r[s] <= '0;
			end
		end else if (cap_en) begin
			result_slot_reg_r[cap_idx] <= core_result_i;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			done_r <= 1'b0;
			done_slot_r <= 4'h0;
		end else begin
			done_r <= cap_en && !soft_rst;
			if (cap_en) begin
				done_slot_r <= cap_idx;
			end
		end
	end

	// ***************
	// configuration registers
	// ***************
	// all slots load from their own address, with no shared fields
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int s = 0; s < N; s++) begin
				slot_control_reg_r[s] <= adc_sched_pkg::SLOT_CTL_RESET;
			end
		end else if (soft_rst) begin
			for (int s = 0; s < N; s++) begin
				slot_control_reg_r[s] <= adc_sched_pkg::SLOT_CTL_RESET;
			end
		end else if (wr_slot) begin
			slot_control_reg_r[addr_idx] <= pwdata_i[15:0];
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sample_mode_r <= 8'h00;
			isel_r <= 32'h0000_0000;
			high_priority_boundary_r <= adc_sched_pkg::BOUND_RESET;
		end else if (soft_rst) begin
			sample_mode_r <= 8'h00;
			isel_r <= 32'h0000_0000;
			high_priority_boundary_r <= adc_sched_pkg::BOUND_RESET;
		end else if (wr_en) begin
			if (paddr_i == adc_sched_pkg::SAMPLE_MODE_OFS) begin
				sample_mode_r <= pwdata_i[7:0];
			end
			if (paddr_i == adc_sched_pkg::ISEL_ONE_OFS) begin
				isel_r[15:0] <= pwdata_i[15:0];
			end
			if (paddr_i == adc_sched_pkg::ISEL_TWO_OFS) begin
				isel_r[31:16] <= pwdata_i[15:0];
			end
			if (wr_prio) begin
				high_priority_boundary_r <= pwdata_i[adc_sched_pkg::BOUND_W-1:0];
			end
		end
	end

	// ***************
	// read mux
	// ***************
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		if (paddr_i[1:0] != 2'h0) begin
			rd_err = 1'b1;
		end else if (paddr_i[7:6] == adc_sched_pkg::SLOT_CTL_PAGE) begin
			rd_data = {16'h0000, slot_control_reg_r[addr_idx]};
		end else if (paddr_i[7:6] == adc_sched_pkg::RESULT_PAGE) begin
			rd_data = {{(32 - RES_W){1'b0}}, result_slot_reg_r[addr_idx]};
		end else begin
			unique case (paddr_i)
				adc_sched_pkg::CTRL_ONE_OFS: rd_data = 32'h0000_0000;
				adc_sched_pkg::SAMPLE_MODE_OFS: rd_data = {24'h00_0000, sample_mode_r};
				adc_sched_pkg::ISEL_ONE_OFS: rd_data = {16'h0000, isel_r[15:0]};
				adc_sched_pkg::ISEL_TWO_OFS: rd_data = {16'h0000, isel_r[31:16]};
				adc_sched_pkg::FORCE_OFS: rd_data = {16'h0000, pend_r};
				adc_sched_pkg::PRIORITY_OFS: begin
					rd_data = {21'h00_0000, last_served_pointer_r, high_priority_boundary_r};
				end
				adc_sched_pkg::STATUS_OFS: rd_data = {24'h00_0000, cur_r, 2'h0, state_r};
				default: rd_err = 1'b1;
			endcase
		end
	end

	// read data is captured in setup so it comes from a flop in access
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			prdata_r <= pwrite_i ? 32'h0000_0000 : rd_data;
			pslverr_r <= rd_err;
		end
	end

	// ***************
	// outputs
	// ***************
	assign prdata_o = prdata_r;
	assign pready_o = 1'b1;
	assign pslverr_o = pslverr_r && psel_i && penable_i;
	assign sample_o = (state_r == adc_sched_pkg::ST_SAMPLE);
	assign convert_o = state_r[1];
	assign channel_o = chan_r;
	assign pair_mode_o = pair_r;
	assign result_done_o = done_r;
	assign result_slot_o = done_slot_r;
endmodule : adc_conversion_slot_scheduler
`default_nettype wire

// ### rtl/adc_sched_pkg.sv
`default_nettype none
package adc_sched_pkg;
	// ***************
	// sizes
	// ***************
	localparam int NUM_SLOTS = 16;
	localparam int TRIG_CODES = 19;
	localparam int CONV_CYCLES = 13;
	localparam logic [5:0] POINTER_RESET = 6'h20;
	// ***************
	// apb byte offsets
	// ***************
	localparam logic [7:0] CTRL_ONE_OFS = 8'h00;
	localparam logic [7:0] SAMPLE_MODE_OFS = 8'h04;
	localparam logic [7:0] ISEL_ONE_OFS = 8'h08;
	localparam logic [7:0] ISEL_TWO_OFS = 8'h0c;
	localparam logic [7:0] FORCE_OFS = 8'h10;
	localparam logic [7:0] PRIORITY_OFS = 8'h14;
	localparam logic [7:0] STATUS_OFS = 8'h18;
	localparam logic [1:0] SLOT_CTL_PAGE = 2'h1;
	localparam logic [1:0] RESULT_PAGE = 2'h2;
	// ***************
	// field layout
	// ***************
	localparam int WIN_LSB = 0;
	localparam int WIN_W = 6;
	localparam int CHAN_LSB = 6;
	localparam int CHAN_W = 4;
	localparam int TSEL_LSB = 11;
	localparam int TSEL_W = 5;
	localparam int MOD_RESET_BIT = 14;
	localparam int BOUND_W = 5;
	localparam int PTR_LSB = 5;
	localparam logic [15:0] SLOT_CTL_RESET = 16'h0000;
	localparam logic [4:0] BOUND_RESET = 5'h00;
	// ***************
	// interrupt-trigger select codes
	// ***************
	localparam logic [1:0] ISEL_NONE = 2'h0;
	localparam logic [1:0] ISEL_IRQ_ONE = 2'h1;
	localparam logic [1:0] ISEL_IRQ_TWO = 2'h2;
	// ***************
	// scheduler states
	// ***************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_CONV_A = 2'b10,
		ST_CONV_B = 2'b11
	} state_type;
endpackage : adc_sched_pkg
`default_nettype wire

// ### rtl/slot_arbiter.sv
`default_nettype none
module slot_arbiter #(
	parameter int NUM = 16
) (
	// requests
	input wire logic [NUM-1:0] pend_i,
	input wire logic [4:0] boundary_i,
	input wire logic [5:0] ptr_i,
	// grant
	output logic valid_o,
	output logic [$clog2(NUM)-1:0] idx_o,
	output logic high_o
);
	int start;
	int j;

	always_comb begin
		start = 0;
		j = 0;
		valid_o = 1'b0;
		idx_o = '0;
		high_o = 1'b0;
		// descending scan so the lowest high-priority slot wins
		for (int i = NUM - 1; i >= 0; i--) begin
			if (pend_i[i] && (i < int'(boundary_i))) begin
				valid_o = 1'b1;
				high_o = 1'b1;
				idx_o = i[$clog2(NUM)-1:0];
			end
		end
		if (!high_o) begin
			// reset pointer value puts slot 0 first on the wheel
			if (ptr_i == adc_sched_pkg::POINTER_RESET) begin
				start = 0;
			end else begin
				start = (int'(ptr_i) + 1) % NUM;
			end
			for (int k = NUM - 1; k >= 0; k--) begin
				j = (start + k) % NUM;
				if (pend_i[j]) begin
					valid_o = 1'b1;
					idx_o = j[$clog2(NUM)-1:0];
				end
			end
		end
	end
endmodule : slot_arbiter
`default_nettype wire

// ### verification/adc_sched_monitor.sv
`default_nettype none
// ************
// port checker
// ************
module adc_sched_monitor (
	// clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// observed
	input wire logic sample_o,
	input wire logic convert_o,
	input wire logic [3:0] channel_o,
	input wire logic pair_mode_o,
	input wire logic result_done_o,
	input wire logic [3:0] result_slot_o
);
	logic [4:0] conv_cnt_r;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!arst_n_i);
	// a pair keeps convert high through both phases, so its run is 26
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			conv_cnt_r <= 5'h00;
		end else begin
			conv_cnt_r <= convert_o ? conv_cnt_r + 5'h01 : 5'h00;
		end
	end
	property p_window_min;
		$rose(sample_o) |-> sample_o [*7];
	endproperty
	a_window_min: assert property (p_window_min)
		else $error("sample window too short");
	property p_conv_len;
		$fell(convert_o) |-> conv_cnt_r == ($past(pair_mode_o) ? 5'h1a : 5'h0d);
	endproperty
	a_conv_len: assert property (p_conv_len)
		else $error("conversion length wrong");
	property p_samp_conv;
		$fell(sample_o) |-> convert_o;
	endproperty
	a_samp_conv: assert property (p_samp_conv)
		else $error("no conversion after sampling");
	property p_one_slot;
		!(sample_o && convert_o);
	endproperty
	a_one_slot: assert property (p_one_slot)
		else $error("sample and convert together");
	property p_done_end;
		$fell(convert_o) |-> result_done_o && !sample_o;
	endproperty
	a_done_end: assert property (p_done_end)
		else $error("no result at conversion end");
	property p_done_cause;
		result_done_o |-> $past(convert_o) && !$past(result_done_o);
	endproperty
	a_done_cause: assert property (p_done_cause)
		else $error("result without conversion");
	property p_chan_hold;
		convert_o || (sample_o && $past(sample_o)) |-> $stable(channel_o);
	endproperty
	a_chan_hold: assert property (p_chan_hold)
		else $error("channel moved in flight");
	property p_pair_chan;
		pair_mode_o && (sample_o || convert_o) |-> !channel_o[3];
	endproperty
	a_pair_chan: assert property (p_pair_chan)
		else $error("pair channel top bit set");
	property p_pair_even;
		result_done_o && convert_o |-> pair_mode_o && !result_slot_o[0];
	endproperty
	a_pair_even: assert property (p_pair_even)
		else $error("first pair result not even");
endmodule : adc_sched_monitor
bind adc_conversion_slot_scheduler adc_sched_monitor u_adc_sched_monitor (
	.clock_i, .arst_n_i, .sample_o, .convert_o, .channel_o, .pair_mode_o,
	.result_done_o, .result_slot_o
);
`default_nettype wire

// ### verification/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0, arst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
	logic pwrite_i = 1'b0, er, sprev = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic pready_o, pslverr_o, sample_o, convert_o, pair_mode_o, result_done_o;
	logic external_irq_two_i, converter_irq_one_i, converter_irq_two_i;
	logic [2:0] timer_irq_i;
	logic [6:0] pwm_event_a_i, pwm_event_b_i;
	logic [11:0] core_result_i;
	logic [3:0] channel_o, result_slot_o;
	int errors = 0, compares = 0, swin = 0;
	always #20 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		sprev <= sample_o;
		if (sample_o) begin
			swin <= sprev ? swin + 1 : 1;
		end
	end
	adc_conversion_slot_scheduler u_adc_conversion_slot_scheduler (
		.clock_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .timer_irq_i, .external_irq_two_i,
		.pwm_event_a_i, .pwm_event_b_i, .converter_irq_one_i, .converter_irq_two_i,
		.core_result_i, .sample_o, .convert_o, .channel_o, .pair_mode_o,
		.result_done_o, .result_slot_o
	);
	trigger_source_model u_trigger_source_model (
		.clock_i, .convert_i(convert_o), .channel_i(channel_o),
		.timer_irq_o(timer_irq_i), .external_irq_two_o(external_irq_two_i),
		.pwm_event_a_o(pwm_event_a_i), .pwm_event_b_o(pwm_event_b_i),
		.converter_irq_one_o(converter_irq_one_i),
		.converter_irq_two_o(converter_irq_two_i), .core_result_o(core_result_i)
	);
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic end_of_test;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test
	// the idle cycle after release keeps two calls from driving psel in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do @(posedge clock_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clock_i);
	endtask : apb
	task automatic cfg(input logic [3:0] s, input logic [15:0] v);
		// every scenario programs a window field of 6 or more
		apb(1'b1, {2'h1, s, 2'h0}, {16'h0, v});
	endtask : cfg
	task automatic fire(input int c);
		u_trigger_source_model.fire(c);
	endtask : fire
	task automatic done(input logic [3:0] s, input logic [3:0] c, input logic b, input int w);
		repeat (300) begin
			@(posedge clock_i);
			if (result_done_o === 1'b1) break;
		end
		chk("done", result_done_o, 32'h1);
		chk("slot", result_slot_o, s);
		chk("window", swin, w + 1);
		apb(1'b0, {2'h2, s, 2'h0}, 32'h0);
		chk("result", rd, {20'h0, 3'h5, b, 4'h0, c});
	endtask : done
	task automatic t_reset;
		apb(1'b0, 8'h14, 32'h0);
		chk("pointer", rd, 32'h400);
		apb(1'b0, 8'h4c, 32'h0);
		chk("slot reset", rd, 32'h0);
	endtask : t_reset
	task automatic t_trig;
		for (int c = 1; c < 19; c++) begin
			cfg(4'h5, 16'(c << 11) | 16'h01c6);
			fire(c);
			done(4'h5, 4'h7, 1'b0, 6);
		end
	endtask : t_trig
	task automatic t_series;
		cfg(4'h0, 16'h4846);
		cfg(4'h1, 16'h4886);
		cfg(4'h2, 16'h48c6);
		fire(9);
		done(4'h0, 4'h1, 1'b0, 6);
		done(4'h1, 4'h2, 1'b0, 6);
		done(4'h2, 4'h3, 1'b0, 6);
		apb(1'b0, 8'h14, 32'h0);
		chk("pointer", rd, 32'h40);
	endtask : t_series
	task automatic t_round;
		cfg(4'hc, 16'h014f);
		apb(1'b1, 8'h10, 32'h1004);
		done(4'hc, 4'h5, 1'b0, 15);
		done(4'h2, 4'h3, 1'b0, 6);
	endtask : t_round
	task automatic t_high;
		apb(1'b1, 8'h14, 32'h4);
		apb(1'b0, 8'h14, 32'h0);
		chk("pointer", rd, 32'h404);
		cfg(4'h3, 16'h0106);
		apb(1'b1, 8'h10, 32'h8);
		done(4'h3, 4'h4, 1'b0, 6);
		apb(1'b0, 8'h14, 32'h0);
		chk("pointer", rd, 32'h404);
		apb(1'b1, 8'h10, 32'h100c);
		done(4'h2, 4'h3, 1'b0, 6);
		done(4'h3, 4'h4, 1'b0, 6);
		done(4'hc, 4'h5, 1'b0, 15);
		apb(1'b0, 8'h14, 32'h0);
		chk("pointer", rd, 32'h184);
		apb(1'b1, 8'h14, 32'h0);
	endtask : t_high
	task automatic t_feedback;
		apb(1'b1, 8'h08, 32'h1000);
		cfg(4'h6, 16'h0a06);
		fire(1);
		repeat (3) @(posedge clock_i);
		chk("no start", sample_o, 32'h0);
		fire(19);
		done(4'h6, 4'h8, 1'b0, 6);
		apb(1'b1, 8'h08, 32'h2000);
		apb(1'b1, 8'h0c, 32'h8);
		cfg(4'h9, 16'h0206);
		fire(20);
		done(4'h9, 4'h8, 1'b0, 6);
		done(4'h6, 4'h8, 1'b0, 6);
	endtask : t_feedback
	task automatic t_pair;
		apb(1'b1, 8'h04, 32'h1);
		cfg(4'h0, 16'h02c6);
		apb(1'b1, 8'h10, 32'h1);
		done(4'h0, 4'h3, 1'b0, 6);
		done(4'h1, 4'h3, 1'b1, 6);
		apb(1'b1, 8'h04, 32'h0);
	endtask : t_pair
	task automatic t_bus;
		apb(1'b0, 8'h3c, 32'h0);
		chk("unmapped err", er, 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, 8'h80, 32'hfff);
		apb(1'b0, 8'h80, 32'h0);
		chk("result ro", rd, 32'ha03);
		chk("mapped err", er, 32'h0);
		chk("ready", pready_o, 32'h1);
	endtask : t_bus
	task automatic t_soft;
		apb(1'b0, 8'h14, 32'h0);
		chk("pointer", rd, 32'h0);
		apb(1'b1, 8'h00, 32'h4000);
		apb(1'b0, 8'h14, 32'h0);
		chk("pointer", rd, 32'h400);
		apb(1'b0, 8'h40, 32'h0);
		chk("slot cleared", rd, 32'h0);
	endtask : t_soft
	initial begin
		#200us;
		errors++;
		end_of_test();
	end
	// channel zero stays unused, it doubles as the high reference
	initial begin
		repeat (2) @(posedge clock_i);
		arst_n_i <= 1'b1;
		@(posedge clock_i);
		t_reset();
		t_trig();
		t_series();
		t_round();
		t_high();
		t_feedback();
		t_pair();
		t_bus();
		t_soft();
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire

// ### verification/trigger_source_model.sv
`default_nettype none
// ************
// trigger sources and converter core
// ************
module trigger_source_model (
	// clock and core view
	input wire logic clock_i,
	input wire logic convert_i,
	input wire logic [3:0] channel_i,
	// triggers
	output logic [2:0] timer_irq_o,
	output logic external_irq_two_o,
	output logic [6:0] pwm_event_a_o,
	output logic [6:0] pwm_event_b_o,
	output logic converter_irq_one_o,
	output logic converter_irq_two_o,
	// core result
	output logic [11:0] core_result_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [20:0] tv_r = 21'h0;
	logic [4:0] ccnt_r = 5'h00;
	logic [11:0] free_r = 12'h000;
	// bit n is trigger code n; 19 and 20 are the converter irq feedbacks
	assign timer_irq_o = tv_r[3:1];
	assign external_irq_two_o = tv_r[4];
	assign converter_irq_one_o = tv_r[19];
	assign converter_irq_two_o = tv_r[20];
	always_comb begin
		for (int k = 0; k < 7; k++) begin
			pwm_event_a_o[k] = tv_r[5 + 2 * k];
			pwm_event_b_o[k] = tv_r[6 + 2 * k];
		end
	end
	// result names channel and phase; outside conversion it churns, so stale data shows
	assign core_result_o = convert_i ? {3'h5, ccnt_r >= 5'h0d, 4'h0, channel_i} : free_r;
	always @(posedge clock_i) begin
		ccnt_r <= convert_i ? ccnt_r + 5'h01 : 5'h00;
		free_r <= free_r + 12'h001;
	end
	task automatic fire(input int c);
		tv_r <= 21'h1 << c;
		@(posedge clock_i);
		tv_r <= 21'h0;
	endtask : fire
endmodule : trigger_source_model
`default_nettype wire
